// *** design/sdci_map.svh ***
// Behaviour
// - burst-of-eight order: sequential wrap or interleave xor
// - four banks; bank lines latched with commands
// - activate captures 13-bit row plus bank
// - read/write captures 9-bit column plus bank
// - everything sampled on rising clock edge
// - gate low freezes state, ignores other inputs
// - gate low with banks idle enters power-down
// - controller raises gate early to exit power-down
// - nop starts nothing, ongoing work continues
// - chip select high ignores command and address
// - read mask hides output two cycles later
// - write mask blocks same-cycle data
// - controller programs mode register after power-up
// - all-low command with gate high writes mode
// - mode write takes two cycles, banks idle
// - mode fields: length, type, latency, write length
// - extended write: bank lines 10, banks precharged
// - extended fields: refresh range, drive strength
// - extended default half drive, full array
// - controller waits activate-to-column delay before column
// - controller spaces activates by bank-to-bank delay
// - controller keeps row open within row active time; precharge-all waits only on the addressed bank
// - latency codes 1..3; burst length codes 1..8, page; here page gives 8 beats and latency does not delay read data
// - drive and refresh range code meanings
`ifndef SDCI_MAP_SVH
`define SDCI_MAP_SVH
`define SDCI_CLK_NS 8
`define SDCI_ACTIVATE_TO_COLUMN_DELAY_NS 18
`define SDCI_BANK_TO_BANK_ACTIVATE_DELAY_NS 12
`define SDCI_ROW_ACTIVE_TIME_MIN_NS 42
`define SDCI_ACTIVATE_TO_COLUMN_DELAY_CYC ((`SDCI_ACTIVATE_TO_COLUMN_DELAY_NS + `SDCI_CLK_NS - 1) / `SDCI_CLK_NS)
`define SDCI_BANK_TO_BANK_ACTIVATE_DELAY_CYC ((`SDCI_BANK_TO_BANK_ACTIVATE_DELAY_NS + `SDCI_CLK_NS - 1) / `SDCI_CLK_NS)
`define SDCI_ROW_ACTIVE_TIME_CYC ((`SDCI_ROW_ACTIVE_TIME_MIN_NS + `SDCI_CLK_NS - 1) / `SDCI_CLK_NS)
`define SDCI_MODE_WRITE_CYC 2
`define SDCI_READ_MASK_LAT 2
`define SDCI_BL_LSB 0
`define SDCI_BT_BIT 3
`define SDCI_CL_LSB 4
`define SDCI_WBL_BIT 9
`define SDCI_PARTIAL_REFRESH_FIELD_LSB 0
`define SDCI_DS_LSB 5
`define SDCI_DS_RESET 2'h1
`define SDCI_PARTIAL_REFRESH_FIELD_RESET 3'h0
`define SDCI_MODE_RESET 13'h0032
`endif

// *** design/sdci_pkg.sv ***
package sdci_pkg;
  typedef logic [12:0] sdci_addr_t;
  typedef logic [1:0] sdci_bank_t;
  typedef logic [31:0] sdci_data_t;
  typedef enum logic [2:0] {
    SDCI_CMD_NOP, SDCI_CMD_ACT, SDCI_CMD_RD, SDCI_CMD_WR,
    SDCI_CMD_MRS, SDCI_CMD_EMRS, SDCI_CMD_PRE
  } sdci_cmd_e;
endpackage : sdci_pkg

// *** design/sdci_if.sv ***
interface sdci_if;
  logic clk_gate;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] bank_select_lines;
  logic [12:0] addr;
  logic dqm;
  logic [31:0] dq_ctl;
  logic dq_ctl_oe;
  logic [31:0] dq_mem;
  logic dq_mem_oe;
  modport ctl (output clk_gate, cs_n, ras_n, cas_n, we_n, bank_select_lines, addr, dqm,
    dq_ctl, dq_ctl_oe, input dq_mem, dq_mem_oe);
  modport mem (input clk_gate, cs_n, ras_n, cas_n, we_n, bank_select_lines, addr, dqm,
    dq_ctl, dq_ctl_oe, output dq_mem, dq_mem_oe);
endinterface : sdci_if

// *** design/sdci_mem.sv ***
`include "sdci_map.svh"
module sdci_mem
  import sdci_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  sdci_if.mem pins,
  output logic power_down,
  output logic suspended,
  output logic [12:0] mode_value,
  output logic [1:0] drive_strength_field,
  output logic [2:0] partial_refresh_field,
  output logic [3:0] bank_open,
  output logic [12:0] open_row [4],
  output logic [1:0] last_bank,
  output logic [8:0] last_col
);
  logic gate_q;
  logic [3:0] open_q;
  logic [12:0] row_q [4];
  logic [12:0] mode_q;
  logic [1:0] ds_q;
  logic [2:0] partial_refresh_field_q;
  logic [1:0] bank_q;
  logic [8:0] col_q;
  logic [2:0] beat_q;
  logic bursting_q;
  logic rd_q;
  logic [1:0] mask_q;
  logic pd_q;
  logic [31:0] mem [0:255];
  logic [31:0] dout_q;
  logic dout_v_q;
  sdci_cmd_e cmd;
  logic live;
  logic [2:0] cur_col;

  // live when the gate was high on the previous edge; freezes otherwise
  assign live = gate_q;

  // decode; chip select high or ras/cas/we high gives a nop
  always_comb begin
    cmd = SDCI_CMD_NOP;
    if (!pins.cs_n) begin
      case ({pins.ras_n, pins.cas_n, pins.we_n})
        3'h3: cmd = SDCI_CMD_ACT;
        3'h5: cmd = SDCI_CMD_RD;
        3'h4: cmd = SDCI_CMD_WR;
        3'h2: cmd = SDCI_CMD_PRE;
        // reserved mode selects 01 and 11 are dropped rather than guessed at
        3'h0: begin
          case (pins.bank_select_lines)
            2'h0: cmd = SDCI_CMD_MRS;
            2'h2: cmd = SDCI_CMD_EMRS;
            default: cmd = SDCI_CMD_NOP;
          endcase
        end
        default: cmd = SDCI_CMD_NOP;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gate_q <= 1'b1;
    end else begin
      gate_q <= pins.clk_gate;
    end
  end

  // power-down when gate sampled low with all banks idle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pd_q <= 1'b0;
    end else if (live && !pins.clk_gate && open_q == 4'h0) begin
      pd_q <= 1'b1;
    end else if (pins.clk_gate) begin
      pd_q <= 1'b0;
    end
  end

  // row state per bank; precharge bit a10 selects all banks
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      open_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        row_q[i] <= 13'h0000;
      end
    end else if (live) begin
      if (cmd == SDCI_CMD_ACT) begin
        open_q[pins.bank_select_lines] <= 1'b1;
        row_q[pins.bank_select_lines] <= pins.addr;
      end else if (cmd == SDCI_CMD_PRE) begin
        if (pins.addr[10]) open_q <= 4'h0;
        else open_q[pins.bank_select_lines] <= 1'b0;
      end
    end
  end

  // mode registers; undefined at power-up so a neutral value is loaded
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= `SDCI_MODE_RESET;
      ds_q <= `SDCI_DS_RESET;
      partial_refresh_field_q <= `SDCI_PARTIAL_REFRESH_FIELD_RESET;
    end else if (live && open_q == 4'h0) begin
      if (cmd == SDCI_CMD_MRS) mode_q <= pins.addr;
      if (cmd == SDCI_CMD_EMRS) begin
        ds_q <= pins.addr[`SDCI_DS_LSB +: 2];
        partial_refresh_field_q <= pins.addr[`SDCI_PARTIAL_REFRESH_FIELD_LSB +: 3];
      end
    end
  end

  // column ordering over a burst of eight
  assign cur_col = mode_q[`SDCI_BT_BIT] ? (col_q[2:0] ^ beat_q)
                                        : (col_q[2:0] + beat_q);

  // burst length code 011 = 8, as does every code above it; codes 000-010 end earlier
  function automatic logic [2:0] last_beat(input logic [2:0] code);
    case (code)
      3'h0: last_beat = 3'h0;
      3'h1: last_beat = 3'h1;
      3'h2: last_beat = 3'h3;
      default: last_beat = 3'h7;
    endcase
  endfunction : last_beat

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bank_q <= 2'h0;
      col_q <= 9'h000;
      beat_q <= 3'h0;
      bursting_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (live) begin
      if (cmd == SDCI_CMD_RD || cmd == SDCI_CMD_WR) begin
        bank_q <= pins.bank_select_lines;
        col_q <= pins.addr[8:0];
        beat_q <= 3'h1;
        bursting_q <= last_beat(pins.addr[2:0] & 3'h0 | mode_q[2:0]) != 3'h0;
        rd_q <= (cmd == SDCI_CMD_RD);
      end else if (bursting_q) begin
        beat_q <= beat_q + 3'h1;
        if (beat_q == last_beat(mode_q[2:0])) bursting_q <= 1'b0;
      end
    end
  end

  // storage of a small window; write mask blocks same-cycle data
  always_ff @(posedge clk_sys) begin
    if (live && !pins.dqm) begin
      if (cmd == SDCI_CMD_WR)
        mem[{pins.bank_select_lines, row_q[pins.bank_select_lines][2:0], pins.addr[2:0]}]
          <= pins.dq_ctl;
      else if (bursting_q && !rd_q)
        mem[{bank_q, row_q[bank_q][2:0], cur_col}] <= pins.dq_ctl;
    end
  end

  // read data one cycle after column; mask delay two cycles
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= 2'h0;
      dout_q <= 32'h0;
      dout_v_q <= 1'b0;
    end else if (live) begin
      mask_q <= {mask_q[0], pins.dqm};
      dout_v_q <= (cmd == SDCI_CMD_RD) || (bursting_q && rd_q);
      if (cmd == SDCI_CMD_RD)
        dout_q <= mem[{pins.bank_select_lines, row_q[pins.bank_select_lines][2:0],
                       pins.addr[2:0]}];
      else
        dout_q <= mem[{bank_q, row_q[bank_q][2:0], cur_col}];
    end
  end

  assign pins.dq_mem = dout_q;
  assign pins.dq_mem_oe = dout_v_q && !mask_q[1];
  assign power_down = pd_q;
  assign suspended = !gate_q;
  assign mode_value = mode_q;
  assign drive_strength_field = ds_q;
  assign partial_refresh_field = partial_refresh_field_q;
  assign bank_open = open_q;
  assign open_row = row_q;
  assign last_bank = bank_q;
  assign last_col = col_q;
endmodule : sdci_mem

// *** design/sdci_ctl.sv ***
`include "sdci_map.svh"
module sdci_ctl
  import sdci_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  sdci_if.ctl pins,
  input wire logic req_valid,
  output logic req_ready,
  input wire sdci_cmd_e req_cmd,
  input wire logic [1:0] req_bank,
  input wire logic [12:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic req_mask,
  input wire logic req_gate,
  output logic [31:0] rdata,
  output logic rdata_valid
);
  logic [3:0] gap_q;
  logic [3:0] rrd_q;
  logic [3:0] rcd_q [4];
  logic [3:0] ras_q [4];
  logic cs_n_q, ras_n_q, cas_n_q, we_n_q, gate_q, dqm_q, oe_q;
  logic [1:0] ba_q;
  logic [12:0] a_q;
  logic [31:0] wd_q;
  logic ok;
  logic take;

  // timing guards the controller itself must keep
  always_comb begin
    case (req_cmd)
      SDCI_CMD_ACT: ok = (rrd_q == 4'h0);
      SDCI_CMD_RD, SDCI_CMD_WR: ok = (rcd_q[req_bank] == 4'h0);
      SDCI_CMD_PRE: ok = (ras_q[req_bank] == 4'h0);
      default: ok = 1'b1;
    endcase
  end
  // mode writes are spaced two cycles
  assign req_ready = (gap_q == 4'h0) && ok;
  assign take = req_valid && req_ready;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= 4'h0;
      rrd_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        rcd_q[i] <= 4'h0;
        ras_q[i] <= 4'h0;
      end
    end else begin
      if (gap_q != 4'h0) gap_q <= gap_q - 4'h1;
      if (rrd_q != 4'h0) rrd_q <= rrd_q - 4'h1;
      for (int i = 0; i < 4; i++) begin
        if (rcd_q[i] != 4'h0) rcd_q[i] <= rcd_q[i] - 4'h1;
        if (ras_q[i] != 4'h0) ras_q[i] <= ras_q[i] - 4'h1;
      end
      if (take && (req_cmd == SDCI_CMD_MRS || req_cmd == SDCI_CMD_EMRS))
        gap_q <= 4'(`SDCI_MODE_WRITE_CYC - 1);
      if (take && req_cmd == SDCI_CMD_ACT) begin
        rrd_q <= 4'(`SDCI_BANK_TO_BANK_ACTIVATE_DELAY_CYC - 1);
        rcd_q[req_bank] <= 4'(`SDCI_ACTIVATE_TO_COLUMN_DELAY_CYC - 1);
        ras_q[req_bank] <= 4'(`SDCI_ROW_ACTIVE_TIME_CYC - 1);
      end
    end
  end

  // pins driven from flops on the rising edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= 4'hf;
      gate_q <= 1'b1;
      dqm_q <= 1'b0;
      oe_q <= 1'b0;
      ba_q <= 2'h0;
      a_q <= 13'h0000;
      wd_q <= 32'h0;
    end else begin
      gate_q <= req_gate;
      dqm_q <= req_mask;
      wd_q <= req_wdata;
      cs_n_q <= !take;
      ba_q <= (take && req_cmd == SDCI_CMD_EMRS) ? 2'h2 : req_bank;
      a_q <= req_addr;
      oe_q <= take && req_cmd == SDCI_CMD_WR;
      case (take ? req_cmd : SDCI_CMD_NOP)
        SDCI_CMD_ACT: {ras_n_q, cas_n_q, we_n_q} <= 3'h3;
        SDCI_CMD_RD: {ras_n_q, cas_n_q, we_n_q} <= 3'h5;
        SDCI_CMD_WR: {ras_n_q, cas_n_q, we_n_q} <= 3'h4;
        SDCI_CMD_PRE: {ras_n_q, cas_n_q, we_n_q} <= 3'h2;
        SDCI_CMD_MRS, SDCI_CMD_EMRS: {ras_n_q, cas_n_q, we_n_q} <= 3'h0;
        default: {ras_n_q, cas_n_q, we_n_q} <= 3'h7;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h0;
      rdata_valid <= 1'b0;
    end else begin
      rdata <= pins.dq_mem;
      rdata_valid <= pins.dq_mem_oe;
    end
  end

  assign pins.clk_gate = gate_q;
  assign pins.cs_n = cs_n_q;
  assign pins.ras_n = ras_n_q;
  assign pins.cas_n = cas_n_q;
  assign pins.we_n = we_n_q;
  assign pins.bank_select_lines = ba_q;
  assign pins.addr = a_q;
  assign pins.dqm = dqm_q;
  assign pins.dq_ctl = wd_q;
  assign pins.dq_ctl_oe = oe_q;
endmodule : sdci_ctl

// *** sim/sdci_props.sv ***
module sdci_props (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_gate,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_select_lines,
  input wire logic [12:0] addr,
  input wire logic dqm,
  input wire logic [31:0] dq_ctl,
  input wire logic dq_ctl_oe,
  input wire logic [31:0] dq_mem,
  input wire logic dq_mem_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic is_any, is_rd, is_wr, is_act, is_mrs, is_emrs;
  // command decode as the memory sees it on the wire
  assign is_any = !cs_n && !(ras_n && cas_n && we_n);
  assign is_rd = !cs_n && ras_n && !cas_n && we_n;
  assign is_wr = !cs_n && ras_n && !cas_n && !we_n;
  assign is_act = !cs_n && !ras_n && cas_n && we_n;
  assign is_mrs = !cs_n && !ras_n && !cas_n && !we_n && bank_select_lines == 2'h0;
  assign is_emrs = !cs_n && !ras_n && !cas_n && !we_n && bank_select_lines == 2'h2;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // a masked beat reopens the output later, so dqm history is excluded
  chk_read_cause:
    assert property ($rose(dq_mem_oe) && !$past(dqm, 3) |-> $past(is_rd))
    else $error("read data without a selected read");
  chk_read_mask:
    assert property ($past(clk_gate) && clk_gate && dqm ##1 clk_gate |=> !dq_mem_oe)
    else $error("read mask did not float output");
  chk_write_data:
    assert property (is_wr |-> dq_ctl_oe)
    else $error("write without same-cycle data");
  chk_mode_fields:
    assert property (is_mrs |-> addr[12:10] == 3'h0 && addr[8:7] == 2'h0)
    else $error("mode write with reserved bits set");
  chk_ext_fields:
    assert property (is_emrs |-> addr[12:7] == 6'h00 && addr[4:3] == 2'h0)
    else $error("extended write with reserved bits set");
  chk_mode_gap:
    assert property (is_mrs || is_emrs |=> !is_any)
    else $error("command inside mode write time");
  chk_act_spacing:
    assert property (is_act |=> !is_act)
    else $error("activates too close");
  chk_act_to_col:
    assert property ((is_rd || is_wr) |-> !($past(is_act) && $past(bank_select_lines) ==
      bank_select_lines) && !($past(is_act, 2) && $past(bank_select_lines, 2) ==
      bank_select_lines)) else $error("column access too soon after activate");
  cov_ext: cover property (is_emrs);
  cov_act_pair: cover property (is_act ##2 is_act);
  cov_wr_mask: cover property (dqm && dq_ctl_oe);
endmodule : sdci_props

// *** sim/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdci_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_mask = 1'b0;
  logic req_gate = 1'b1;
  sdci_cmd_e req_cmd = SDCI_CMD_NOP;
  logic [1:0] req_bank = 2'h0;
  logic [12:0] req_addr = 13'h0000;
  logic [31:0] req_wdata = 32'h0000_0000;
  logic req_ready, rdata_valid, power_down, suspended;
  logic [31:0] rdata;
  logic [12:0] mode_value;
  logic [1:0] drive_strength_field, last_bank;
  logic [2:0] partial_refresh_field;
  logic [3:0] bank_open;
  logic [12:0] open_row [4];
  logic [8:0] last_col;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] seed = 32'd63996;
  logic [31:0] mem_m [int];
  logic [12:0] row_m [4];
  logic [31:0] got [$];
  logic [31:0] exp_q [$];
  // both ends face each other; the checker watches the wire
  sdci_if sdci_if_inst ();
  sdci_ctl sdci_ctl_inst (.clk_sys, .reset_n, .pins(sdci_if_inst.ctl), .req_valid, .req_ready,
    .req_cmd, .req_bank, .req_addr, .req_wdata, .req_mask, .req_gate, .rdata, .rdata_valid);
  sdci_mem sdci_mem_inst (.clk_sys, .reset_n, .pins(sdci_if_inst.mem), .power_down, .suspended,
    .mode_value, .drive_strength_field, .partial_refresh_field, .bank_open, .open_row,
    .last_bank, .last_col);
  sdci_props sdci_props_inst (.clk_sys, .reset_n, .clk_gate(sdci_if_inst.clk_gate),
    .cs_n(sdci_if_inst.cs_n), .ras_n(sdci_if_inst.ras_n), .cas_n(sdci_if_inst.cas_n),
    .we_n(sdci_if_inst.we_n), .bank_select_lines(sdci_if_inst.bank_select_lines),
    .addr(sdci_if_inst.addr), .dqm(sdci_if_inst.dqm), .dq_ctl(sdci_if_inst.dq_ctl),
    .dq_ctl_oe(sdci_if_inst.dq_ctl_oe), .dq_mem(sdci_if_inst.dq_mem),
    .dq_mem_oe(sdci_if_inst.dq_mem_oe));
  // 125 mhz system clock
  always #4 clk_sys = ~clk_sys;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    check_count++;
    if (seen !== expv) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask : check
  task automatic results();
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // valid stays up until ready is seen at an edge; bounded wait
  task automatic req(input sdci_cmd_e c, input logic [1:0] b, input logic [12:0] a,
    input logic [31:0] d);
    int n = 0;
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    req_wdata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    if (n >= 100) err_count++;
  endtask : req
  task automatic idle(input int n);
    repeat (n) begin
      req_valid <= 1'b0;
      @(posedge clk_sys);
    end
  endtask : idle
  // gate low: idle banks power down, open banks only suspend
  task automatic gate_check(input logic pd);
    req_gate <= 1'b0;
    idle(4);
    check(power_down, pd);
    if (!pd) check(suspended, 1'b1);
    req_gate <= 1'b1;
    idle(4);
    check(power_down, 1'b0);
    check(suspended, 1'b0);
  endtask : gate_check
  // model stores each beat unless its mask was up in that cycle
  task automatic wr_burst(input logic [1:0] b, input logic [2:0] col, input logic bt,
    input int mk);
    logic [31:0] d;
    logic [2:0] c;
    for (int k = 0; k < 8; k++) begin
      d = rnd();
      c = bt ? (col ^ k[2:0]) : (col + k[2:0]);
      if (k != mk) mem_m[{b, row_m[b][2:0], c}] = d;
      if (k == 0) begin
        req_mask <= (mk == 0);
        req(SDCI_CMD_WR, b, {10'h000, col}, d);
      end else begin
        req_valid <= 1'b0;
        req_wdata <= d;
        req_mask <= (k == mk);
        @(posedge clk_sys);
      end
    end
    req_mask <= 1'b0;
  endtask : wr_burst
  // mask raised mj cycles after the read takes out beat mj+1
  task automatic rd_burst(input logic [1:0] b, input logic [2:0] col, input logic bt,
    input int mj);
    logic [2:0] c;
    got.delete();
    exp_q.delete();
    for (int k = 0; k < 8; k++) begin
      c = bt ? (col ^ k[2:0]) : (col + k[2:0]);
      if (k != mj + 1) exp_q.push_back(mem_m[{b, row_m[b][2:0], c}]);
    end
    req(SDCI_CMD_RD, b, {10'h000, col}, 32'h0000_0000);
    for (int i = 1; i < 15; i++) begin
      req_valid <= 1'b0;
      req_mask <= (i == mj);
      @(posedge clk_sys);
      if (rdata_valid === 1'b1) got.push_back(rdata);
    end
    check(got.size(), exp_q.size());
    foreach (exp_q[k]) check(got.size() > k ? got[k] : 32'hx, exp_q[k]);
  endtask : rd_burst
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    check(mode_value, 13'h0032);
    check(drive_strength_field, 2'h1);
    check(partial_refresh_field, 3'h0);
    check(bank_open, 4'h0);
    $display("done: reset");
    gate_check(1'b1);
    $display("done: power down");
    for (int ds = 0; ds < 4; ds++) begin
      for (int pr = 0; pr < 3; pr++) begin
        req(SDCI_CMD_EMRS, 2'h2, {6'h00, ds[1:0], 2'h0, pr[2:0]}, 32'h0000_0000);
        idle(3);
        check(drive_strength_field, ds[1:0]);
        check(partial_refresh_field, pr[2:0]);
      end
    end
    for (int cl = 1; cl < 4; cl++) begin
      for (int bl = 0; bl < 4; bl++) begin
        req(SDCI_CMD_MRS, 2'h0, {6'h00, cl[2:0], 1'b0, bl[2:0]}, 32'h0000_0000);
        idle(3);
        check(mode_value, {6'h00, cl[2:0], 1'b0, bl[2:0]});
      end
    end
    // second write hits the gap and must be held off
    req(SDCI_CMD_MRS, 2'h0, 13'h002b, 32'h0000_0000);
    req(SDCI_CMD_MRS, 2'h0, 13'h0023, 32'h0000_0000);
    idle(3);
    check(mode_value, 13'h0023);
    $display("done: mode writes");
    for (int b = 0; b < 4; b++) begin
      row_m[b] = 13'(rnd());
      req(SDCI_CMD_ACT, b[1:0], row_m[b], 32'h0000_0000);
    end
    idle(4);
    check(bank_open, 4'hf);
    foreach (row_m[b]) check(open_row[b], row_m[b]);
    gate_check(1'b0);
    $display("done: activate and suspend");
    wr_burst(2'h1, 3'h0, 1'b0, 20);
    check(last_bank, 2'h1);
    check(last_col, 9'h000);
    wr_burst(2'h1, 3'h4, 1'b0, 2);
    rd_burst(2'h1, 3'h5, 1'b0, 20);
    $display("done: sequential bursts");
    for (int b = 0; b < 4; b++) req(SDCI_CMD_PRE, b[1:0], 13'h0000, 32'h0000_0000);
    idle(3);
    check(bank_open, 4'h0);
    req(SDCI_CMD_MRS, 2'h0, 13'h002b, 32'h0000_0000);
    req(SDCI_CMD_ACT, 2'h1, row_m[1], 32'h0000_0000);
    rd_burst(2'h1, 3'h5, 1'b1, 2);
    $display("done: interleave masked read");
    results();
  end
  // hang guard, about twenty-four times the expected run
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    results();
  end
endmodule : tb
